/* verilog/cmp_pkg.sv */
// constants, register map and write helper for the dual comparator block
// assumes byte addressing on a 32-bit register bus, one 16-byte slot per register
`default_nettype none

package cmp_pkg;

  // register map, byte addresses within the block
  localparam logic [11:0] STAT_OFS  = 12'h900;
  localparam logic [11:0] CTL1_OFS  = 12'h910;
  localparam logic [11:0] CTL2_OFS  = 12'h930;
  localparam logic [11:0] IST_OFS   = 12'h940;
  localparam logic [11:0] IMSK_OFS  = 12'h950;

  localparam int          NUM_CMP   = 2;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;

  // control word fields
  localparam int EN_BIT    = 15;
  localparam int OE_BIT    = 14;
  localparam int INV_BIT   = 13;
  localparam int EVT_BIT   = 9;
  localparam int RES_BIT   = 8;
  localparam int TRIGGER_POLARITY_LSB = 6;
  localparam int CREF_BIT  = 4;
  localparam int CCH_LSB   = 0;

  // status word fields
  localparam int STAT_IDLE_BIT = 13;
  localparam int STAT_REF_BIT  = 8;
  localparam int STAT_EVT_LSB  = 16;
  localparam int STAT_RES_LSB  = 0;

  // bits that software may store, plus the event bit it may only clear
  localparam logic [31:0] CTL_WMASK  = 32'h0000_e0d3;
  localparam logic [31:0] STAT_WMASK = 32'h0000_2100;
  localparam logic [31:0] IRQ_WMASK  = 32'h0000_0003;
  localparam logic [31:0] EVT_MASK   = 32'h0000_0200;

  // trigger polarity codes
  localparam logic [1:0] EV_OFF  = 2'h0;
  localparam logic [1:0] EV_RISE = 2'h1;
  localparam logic [1:0] EV_FALL = 2'h2;
  localparam logic [1:0] EV_ANY  = 2'h3;

  // address bits 3:2 pick the plain, clear, set or invert alias
  typedef enum logic [1:0] {WR_PLAIN, WR_CLR, WR_SET, WR_INV} wr_kind_t;

  function automatic logic [31:0] apply_write(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be,
                                              input wr_kind_t    kind,
                                              input logic [31:0] wmask);
    logic [31:0] m;
    m = wmask & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    unique case (kind)
      WR_PLAIN: apply_write = (old & ~m) | (wd & m);
      WR_CLR:   apply_write = old & ~(wd & m);
      WR_SET:   apply_write = old | (wd & m);
      WR_INV:   apply_write = old ^ (wd & m);
    endcase
  endfunction

endpackage

`default_nettype wire

/* verilog/comparator_link_if.sv */
// link between the register bank and one comparator channel
// assumes both ends run on sys_clk
`timescale 1ns/100ps
`default_nettype none

interface comparator_link_if;
  logic       run;
  logic       invert;
  logic [1:0] trigger_polarity;
  logic       evt_clr;
  logic       result_bit;
  logic       event_latch;
  logic       trig;

  modport bank (output run, output invert, output trigger_polarity, output evt_clr,
                input result_bit, input event_latch, input trig);
  modport chan (input run, input invert, input trigger_polarity, input evt_clr,
                output result_bit, output event_latch, output trig);
endinterface

`default_nettype wire

/* verilog/comparator_channel.sv */
// one comparator channel: synchroniser, polarity, edge detect, event latch
// assumes raw_in is asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module comparator_channel
  import cmp_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // analog comparator result
  input  wire logic raw_in,
  // register bank side
  comparator_link_if.chan lnk
);

  logic [2:0] sync_r, sync_nxt;
  logic       stable_r, stable_nxt;
  logic       res_r, res_nxt;
  logic       prev_r, prev_nxt;
  logic       latch_r, latch_nxt;
  logic       sel;

  always_comb begin
    sync_nxt   = {sync_r[1:0], raw_in};
    // a change counts only once second and third stage agree
    stable_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : stable_r;
    // disabled channel reads low and cannot trigger
    res_nxt    = lnk.run ? (stable_r ^ lnk.invert) : 1'b0;
    prev_nxt   = res_r;
    // edges seen after inversion, so rise and fall swap with polarity
    unique case (lnk.trigger_polarity)
      EV_RISE: sel = res_r & ~prev_r;
      EV_FALL: sel = ~res_r & prev_r;
      EV_ANY:  sel = res_r ^ prev_r;
      EV_OFF:  sel = 1'b0;
    endcase
    // a trigger in the clearing cycle is kept: set beats clear
    lnk.trig  = lnk.run & sel & (~latch_r | lnk.evt_clr);
    latch_nxt = lnk.trig | (latch_r & ~lnk.evt_clr);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r   <= 3'h0;
      stable_r <= 1'b0;
      res_r    <= 1'b0;
      prev_r   <= 1'b0;
      latch_r  <= 1'b0;
    end else begin
      sync_r   <= sync_nxt;
      stable_r <= stable_nxt;
      res_r    <= res_nxt;
      prev_r   <= prev_nxt;
      latch_r  <= latch_nxt;
    end
  end

  assign lnk.result_bit  = res_r;
  assign lnk.event_latch = latch_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_latched;
    latch_r && !lnk.evt_clr;
  endsequence

  a_evt_holds: assert property (s_latched |=> latch_r)
    else $error("event latch dropped without a clear");
  a_evt_sets: assert property (lnk.trig |=> latch_r ##0 (!lnk.trig || lnk.evt_clr))
    else $error("trigger did not set the event latch");
  a_evt_off: assert property (lnk.trigger_polarity == EV_OFF |-> !lnk.trig)
    else $error("trigger while events disabled");
  a_off_low: assert property (!lnk.run ##1 !lnk.run |-> !res_r)
    else $error("disabled comparator shows a result");

endmodule

`default_nettype wire

/* verilog/dual_comparator_control_status.sv */
// register bank and control for a module of two analog comparators
// assumes an Avalon-MM master on sys_clk, byte addresses, 32-bit data
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module dual_comparator_control_status
  import cmp_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // device power state
  input  wire logic        idle_mode,
  // analog comparator cores
  input  wire logic [1:0]  cmp_raw,
  output logic      [1:0]  cmp_enable,
  output logic      [1:0]  cmp_ref_input,
  output logic      [3:0]  cmp_channel_sel,
  output logic             reference_source_select,
  // comparator output pins
  output logic      [1:0]  comparator_output_pin,
  output logic      [1:0]  comparator_output_pin_oe,
  // interrupt
  output logic             irq
);

  logic [NUM_CMP-1:0][31:0] ctl_r, ctl_nxt;
  logic [31:0]              stat_r, stat_nxt;
  logic [31:0]              ist_r, ist_nxt;
  logic [31:0]              imsk_r, imsk_nxt;
  logic [31:0]              rdata_r, rdata_nxt;
  logic                     rd_done_r, rd_done_nxt;

  logic [NUM_CMP-1:0] run_v;
  logic [NUM_CMP-1:0] evt_clr_v;
  logic [NUM_CMP-1:0] res_v;
  logic [NUM_CMP-1:0] latch_v;
  logic [NUM_CMP-1:0] trig_v;

  logic [11:0] base;
  wr_kind_t    kind;

  function automatic logic [11:0] ctl_ofs(input int idx);
    ctl_ofs = (idx == 0) ? CTL1_OFS : CTL2_OFS;
  endfunction

  // control word as software sees it, hardware bits merged in
  function automatic logic [31:0] ctl_view(input logic [31:0] stored,
                                           input logic        latch,
                                           input logic        res);
    ctl_view = stored & CTL_WMASK;
    ctl_view[EVT_BIT] = latch;
    ctl_view[RES_BIT] = res;
  endfunction

  // status word: stored options plus live mirrors of each channel
  function automatic logic [31:0] stat_view(input logic [31:0]        stored,
                                            input logic [NUM_CMP-1:0] latch,
                                            input logic [NUM_CMP-1:0] res);
    stat_view = stored & STAT_WMASK;
    stat_view[STAT_EVT_LSB +: NUM_CMP] = latch;
    stat_view[STAT_RES_LSB +: NUM_CMP] = res;
  endfunction

  assign base = {address[11:4], 4'h0};
  assign kind = wr_kind_t'(address[3:2]);

  // register bank next state
  always_comb begin
    logic [31:0] wv;
    wv          = 32'h0000_0000;
    ctl_nxt     = ctl_r;
    stat_nxt    = stat_r;
    imsk_nxt    = imsk_r;
    rdata_nxt   = rdata_r;
    evt_clr_v   = '0;
    ist_nxt     = ist_r;
    // reads answer one cycle after the request is seen
    rd_done_nxt = read & ~rd_done_r;

    if (write) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (base == ctl_ofs(i)) begin
          // event bit goes through the write so aliases can clear it
          wv = apply_write(ctl_view(ctl_r[i], latch_v[i], res_v[i]),
                           writedata, byteenable, kind,
                           CTL_WMASK | EVT_MASK);
          ctl_nxt[i] = wv & CTL_WMASK;
          // software may only clear the latch, never set it
          evt_clr_v[i] = latch_v[i] & ~wv[EVT_BIT];
        end
      end
      if (base == STAT_OFS) begin
        // mirror bits are outside the mask, so writes pass them by
        stat_nxt = apply_write(stat_r, writedata, byteenable, kind,
                               STAT_WMASK);
      end
      if (address == IMSK_OFS) begin
        imsk_nxt = apply_write(imsk_r, writedata, byteenable, WR_PLAIN, IRQ_WMASK);
      end
      if (address == IST_OFS) begin
        ist_nxt = apply_write(ist_r, writedata, byteenable, WR_CLR, IRQ_WMASK);
      end
    end
    // new events win over a clear in the same cycle
    ist_nxt[NUM_CMP-1:0] = ist_nxt[NUM_CMP-1:0] | trig_v;

    if (read && !rd_done_r) begin
      if (base == STAT_OFS) begin
        rdata_nxt = stat_view(stat_r, latch_v, res_v);
      end else if (base == CTL1_OFS) begin
        rdata_nxt = ctl_view(ctl_r[0], latch_v[0], res_v[0]);
      end else if (base == CTL2_OFS) begin
        rdata_nxt = ctl_view(ctl_r[1], latch_v[1], res_v[1]);
      end else if (address == IST_OFS) begin
        rdata_nxt = ist_r;
      end else if (address == IMSK_OFS) begin
        rdata_nxt = imsk_r;
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r     <= {NUM_CMP{RESET_VAL}};
      stat_r    <= RESET_VAL;
      ist_r     <= RESET_VAL;
      imsk_r    <= RESET_VAL;
      rdata_r   <= RESET_VAL;
      rd_done_r <= 1'b0;
    end else begin
      ctl_r     <= ctl_nxt;
      stat_r    <= stat_nxt;
      ist_r     <= ist_nxt;
      imsk_r    <= imsk_nxt;
      rdata_r   <= rdata_nxt;
      rd_done_r <= rd_done_nxt;
    end
  end

  // writes never stall; a read waits exactly one cycle
  assign waitrequest = read & ~rd_done_r;
  assign readdata    = rdata_r;

  assign irq = |(ist_r[NUM_CMP-1:0] & imsk_r[NUM_CMP-1:0]);

  assign reference_source_select = stat_r[STAT_REF_BIT];

  comparator_link_if link [NUM_CMP] ();

  for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
    // idle-stop halts all channels, enabled or not
    assign run_v[g] = ctl_r[g][EN_BIT]
                      & ~(stat_r[STAT_IDLE_BIT] & idle_mode);

    assign link[g].run              = run_v[g];
    assign link[g].invert           = ctl_r[g][INV_BIT];
    assign link[g].trigger_polarity = ctl_r[g][TRIGGER_POLARITY_LSB +: 2];
    assign link[g].evt_clr          = evt_clr_v[g];
    assign res_v[g]                 = link[g].result_bit;
    assign latch_v[g]               = link[g].event_latch;
    assign trig_v[g]                = link[g].trig;

    assign cmp_enable[g]            = run_v[g];
    assign cmp_ref_input[g]         = ctl_r[g][CREF_BIT];
    assign cmp_channel_sel[2*g +: 2] = ctl_r[g][CCH_LSB +: 2];

    // pin path bypasses the synchroniser on purpose: lowest latency,
    // so the pin may glitch where the status bit does not
    assign comparator_output_pin[g] = ctl_r[g][OE_BIT]
                                      & (cmp_raw[g] ^ ctl_r[g][INV_BIT]);
    assign comparator_output_pin_oe[g] = ctl_r[g][OE_BIT];

    comparator_channel u_chan (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .raw_in  (cmp_raw[g]),
      .lnk     (link[g])
    );
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_set_write1;
    write && address == (CTL1_OFS + 12'h008) && byteenable == 4'hf;
  endsequence

  a_pin_route: assert property (comparator_output_pin_oe[0] |->
      comparator_output_pin[0] == (cmp_raw[0] ^ ctl_r[0][INV_BIT]))
    else $error("pin does not carry the raw comparator output");
  a_evt_mirror: assert property (read && !rd_done_r && base == STAT_OFS |=>
      readdata[17:16] == $past(latch_v))
    else $error("status event bits differ from latches");
  a_res_mirror: assert property (read && !rd_done_r && base == STAT_OFS |=>
      readdata[1:0] == $past(res_v))
    else $error("status result bits differ from channels");
  a_stat_ro: assert property (write && base == STAT_OFS |=>
      ((stat_r & ~STAT_WMASK) == 32'h0000_0000))
    else $error("read-only status bits were stored");
  a_idle_halt: assert property (stat_r[STAT_IDLE_BIT] && idle_mode |-> run_v == '0)
    else $error("comparator runs in idle with idle-stop set");
  a_alias_set: assert property (s_set_write1 |=>
      ((ctl_r[0] & $past(writedata) & CTL_WMASK) == ($past(writedata) & CTL_WMASK)))
    else $error("set alias did not set the written bits");
  a_high_zero: assert property (rd_done_r && base == STAT_OFS |-> readdata[31:18] == 14'h0)
    else $error("unimplemented status bits read nonzero");
  a_rd_wait: assert property (read && !rd_done_r |-> waitrequest ##1 (!waitrequest || !read))
    else $error("read not answered after one wait cycle");

  // readdata must hold between reads: software may sample it late
  a_rd_stands: assert property (!(read && !rd_done_r) |=> $stable(readdata))
    else $error("read data changed without a read");

  sequence s_rd_unmapped;
    read && !rd_done_r && base != STAT_OFS && base != CTL1_OFS && base != CTL2_OFS
      && address != IST_OFS && address != IMSK_OFS;
  endsequence

  a_rd_unmapped: assert property (s_rd_unmapped |=> readdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  // hardware-only bits must never reach the stored control words
  a_ctl_unimpl: assert property (
      ((ctl_r[0] | ctl_r[1]) & ~CTL_WMASK) == 32'h0000_0000)
    else $error("control word stored a read-only or unused bit");

  sequence s_ctl2_write;
    write && base == CTL2_OFS;
  endsequence

  // one decoder serves both words, so a slip would corrupt the other channel
  a_ctl_apart: assert property (s_ctl2_write |=> ctl_r[0] == $past(ctl_r[0]))
    else $error("second control write changed the first control word");

  a_ctl_mirror: assert property (read && !rd_done_r && base == CTL2_OFS |=>
      readdata[EVT_BIT] == $past(latch_v[1]) && readdata[RES_BIT] == $past(res_v[1]))
    else $error("control word hardware bits differ from channel");

  // software may clear the latch but never set it
  a_sw_no_set: assert property (write && base == CTL1_OFS && !latch_v[0] && !trig_v[0]
      |=> !latch_v[0])
    else $error("software write set the event latch");

  sequence s_evt1_clr_alias;
    write && base == CTL1_OFS && kind == WR_CLR && writedata[EVT_BIT] && byteenable[1];
  endsequence

  // a trigger in the same cycle keeps the latch, so it is excluded here
  a_evt_clear: assert property (s_evt1_clr_alias ##0 !trig_v[0] |=> !latch_v[0])
    else $error("clear alias left the event latch set");

  sequence s_trig_any;
    trig_v != '0;
  endsequence

  // new events must survive a clear of the interrupt status in the same cycle
  a_ist_set: assert property (s_trig_any |=>
      (ist_r[NUM_CMP-1:0] & $past(trig_v)) == $past(trig_v))
    else $error("trigger did not set the interrupt status");

  sequence s_stat_inv;
    write && base == STAT_OFS && kind == WR_INV && byteenable[1];
  endsequence

  a_inv_alias: assert property (s_stat_inv |=>
      stat_r[STAT_IDLE_BIT] == ($past(stat_r[STAT_IDLE_BIT]) ^ $past(writedata[STAT_IDLE_BIT])))
    else $error("invert alias did not toggle idle-stop");

  // reference choice goes straight to the analog mux, no staging
  a_ref_select: assert property (write && base == STAT_OFS && kind == WR_PLAIN
      && byteenable[1] |=> reference_source_select == $past(writedata[STAT_REF_BIT]))
    else $error("reference select does not follow the status write");

  // second channel pin, same unsynchronised path as the first
  a_pin_second: assert property (comparator_output_pin_oe[1] |->
      comparator_output_pin[1] == (cmp_raw[1] ^ ctl_r[1][INV_BIT]))
    else $error("second pin does not carry the raw comparator output");

endmodule

`default_nettype wire

/* testbench/cmp_core_model.sv */
// behavioural model of the two analog comparator cores
// assumes the bench gives each input relation as a level
`timescale 1ns/100ps
`default_nettype none

module cmp_core_model (
  // run request from the control logic
  input  wire logic [1:0] run,
  // input relation, high while plus input is above minus input
  input  wire logic [1:0] level,
  // raw comparator outputs
  output logic      [1:0] raw
);
  // a stopped core parks low so a stale result cannot leak out
  assign raw = run & level;
endmodule

`default_nettype wire

/* testbench/tb_dual_comparator_control_status.sv */
// self-checking bench for the dual comparator register bank
// assumes cmp_core_model stands in for the analog cores
`timescale 1ns/100ps
`default_nettype none

module tb_dual_comparator_control_status import cmp_pkg::*;;
  logic        sys_clk;
  logic        rst_n;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        idle_mode;
  logic [1:0]  cmp_raw;
  logic [1:0]  cmp_enable;
  logic [1:0]  cmp_ref_input;
  logic [3:0]  cmp_channel_sel;
  logic        reference_source_select;
  logic [1:0]  comparator_output_pin;
  logic [1:0]  comparator_output_pin_oe;
  logic        irq;
  logic [1:0]  level;
  int          failures;
  int          samples_checked;

  dual_comparator_control_status dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .idle_mode(idle_mode), .cmp_raw(cmp_raw),
    .cmp_enable(cmp_enable), .cmp_ref_input(cmp_ref_input),
    .cmp_channel_sel(cmp_channel_sel), .reference_source_select(reference_source_select),
    .comparator_output_pin(comparator_output_pin),
    .comparator_output_pin_oe(comparator_output_pin_oe), .irq(irq));

  cmp_core_model cores (.run(cmp_enable), .level(level), .raw(cmp_raw));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // waitrequest and readdata are taken at the rising edge, before that edge's updates land;
  // only the watchdog ends a wait that never finishes
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic t_reset;
    rd_chk(STAT_OFS, 32'h0);
    rd_chk(CTL1_OFS, 32'h0);
    rd_chk(CTL2_OFS, 32'h0);
    rd_chk(IST_OFS, 32'h0);
    rd_chk(12'h920, 32'h0);
    chk({27'h0, irq, comparator_output_pin_oe, comparator_output_pin}, 32'h0);
  endtask

  task automatic t_status;
    wr(STAT_OFS, 32'hffff_ffff);
    rd_chk(STAT_OFS, 32'h0000_2100);
    chk({31'h0, reference_source_select}, 32'h1);
    wr(STAT_OFS + 12'h4, 32'h0000_0100);
    rd_chk(STAT_OFS, 32'h0000_2000);
    chk({31'h0, reference_source_select}, 32'h0);
    wr(STAT_OFS + 12'h8, 32'h0000_0100);
    rd_chk(STAT_OFS, 32'h0000_2100);
    wr(STAT_OFS + 12'hc, 32'h0000_2100);
    rd_chk(STAT_OFS, 32'h0);
  endtask

  task automatic t_control(input int ch);
    logic [11:0] ofs;
    ofs = (ch == 1) ? CTL2_OFS : CTL1_OFS;
    wr(ofs + 12'h8, 32'hffff_7fff);
    rd_chk(ofs, 32'h0000_60d3);
    rd_chk((ch == 1) ? CTL1_OFS : CTL2_OFS, 32'h0);
    chk({31'h0, comparator_output_pin_oe[ch]}, 32'h1);
    chk({29'h0, cmp_ref_input[ch], cmp_channel_sel[2*ch +: 2]}, 32'h7);
    chk({31'h0, cmp_enable[ch]}, 32'h0);
    chk({31'h0, comparator_output_pin[ch]}, 32'h1);
    wr(ofs + 12'h4, 32'hffff_ffff);
    rd_chk(ofs, 32'h0);
  endtask

  task automatic t_event(input int ch, input logic [1:0] pol, input logic inv);
    logic [11:0] ofs;
    logic        fr;
    logic        ff;
    logic [31:0] ctl;
    ofs = (ch == 1) ? CTL2_OFS : CTL1_OFS;
    fr  = (pol == EV_ANY) || (pol == EV_RISE && !inv) || (pol == EV_FALL && inv);
    ff  = (pol == EV_ANY) || (pol == EV_FALL && !inv) || (pol == EV_RISE && inv);
    ctl = 32'h0000_c000 | ({31'h0, inv} << 13) | ({30'h0, pol} << 6);
    level <= 2'b00;
    wr(IMSK_OFS, 32'h3);
    wr(ofs, ctl);
    // enabling may itself count as an edge, so settle and clear first
    repeat (10) @(posedge sys_clk);
    wr(ofs + 12'h4, EVT_MASK);
    wr(ofs + 12'h8, EVT_MASK);
    wr(IST_OFS, 32'h3);
    rd_chk(ofs, ctl | ({31'h0, inv} << 8));
    level[ch] <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk({31'h0, comparator_output_pin[ch]}, {31'h0, ~inv});
    rd_chk(STAT_OFS, ({31'h0, fr} << (16 + ch)) | ({31'h0, ~inv} << ch));
    rd_chk(IST_OFS, {31'h0, fr} << ch);
    chk({31'h0, irq}, {31'h0, fr});
    wr(IST_OFS, 32'h3);
    level[ch] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd_chk(ofs, ctl | ({31'h0, fr | ff} << 9) | ({31'h0, inv} << 8));
    rd_chk(IST_OFS, {31'h0, ff & ~fr} << ch);
    wr(IMSK_OFS, 32'h0);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(ofs, 32'h0);
  endtask

  task automatic t_idle;
    wr(CTL1_OFS, 32'h0000_8000);
    @(negedge sys_clk);
    chk({30'h0, cmp_enable}, 32'h1);
    @(posedge sys_clk);
    idle_mode <= 1'b1;
    wr(STAT_OFS, 32'h0000_2000);
    @(negedge sys_clk);
    chk({30'h0, cmp_enable}, 32'h0);
    wr(STAT_OFS, 32'h0);
    @(negedge sys_clk);
    chk({30'h0, cmp_enable}, 32'h1);
    wr(CTL1_OFS, 32'h0);
    @(negedge sys_clk);
    chk({30'h0, cmp_enable}, 32'h0);
    @(posedge sys_clk);
    idle_mode <= 1'b0;
  endtask

  initial begin
    rst_n           = 1'b0;
    address         = 12'h0;
    read            = 1'b0;
    write           = 1'b0;
    writedata       = 32'h0;
    byteenable      = 4'hf;
    idle_mode       = 1'b0;
    level           = 2'h0;
    failures        = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_status();
    t_control(0);
    t_control(1);
    for (int ch = 0; ch < 2; ch++) begin
      for (int p = 0; p < 4; p++) begin
        for (int v = 0; v < 2; v++) begin
          t_event(ch, p[1:0], v[0]);
        end
      end
    end
    t_idle();
    wrap_up();
  end

  // whole run needs about a thousand cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
endmodule

`default_nettype wire
